// ---- verification/psc_checker_asserts.sv ----
`timescale 1ns/1ps
// Watches the sequencing outputs against the control pins
module psc_checker #(
    parameter CTRL_CYCLES = 4
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire enable_in,
    input wire start_in,
    input wire jog_plus_in,
    input wire jog_minus_in,
    input wire [15:0] demand_pos_in,
    input wire [15:0] actual_pos_in,
    input wire [15:0] ext_speed_in,
    input wire [15:0] speed_limit_param_in,
    input wire speed_source_select_in,
    input wire [15:0] jog_speed_in,
    input wire ready_out,
    input wire in_position_flag_out,
    input wire jog_mode_out,
    input wire valve_enable_out,
    input wire [15:0] valve_cmd_out,
    input wire [15:0] required_pos_out
);
    // Jog speed clipped to the active limit, halved as the valve sees it
    wire [15:0] lim = speed_source_select_in ? ext_speed_in : speed_limit_param_in;
    wire [15:0] jog_half = ((jog_speed_in < lim) ? jog_speed_in : lim) >> 1;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_valve_idle_zero: assert property (!valve_enable_out |-> valve_cmd_out == 16'h0000)
        else $error("valve command nonzero while disabled");
    a_ready_needs_enable: assert property (ready_out |-> valve_enable_out)
        else $error("ready without valve enable");
    a_enable_drop_off: assert property ($fell(enable_in) |-> ##[1:4] (!valve_enable_out && !ready_out))
        else $error("valve still enabled after enable loss");
    a_load_actual: assert property ($rose(valve_enable_out) |-> required_pos_out == $past(actual_pos_in))
        else $error("required position not loaded from actual");
    a_in_position_flag_with_start: assert property ($rose(in_position_flag_out) |-> $past(start_in, 3) && required_pos_out == $past(demand_pos_in))
        else $error("in position without start or demand");
    a_jog_entry_ok: assert property ($rose(jog_mode_out) |-> !$past(start_in, 3) && ($past(jog_plus_in, 3) != $past(jog_minus_in, 3)))
        else $error("jog entered while refused");
    a_jog_speed_sign: assert property ($rose(jog_mode_out) |-> valve_cmd_out == ($past(jog_plus_in, 3) ? jog_half : 16'h0000 - jog_half))
        else $error("jog valve command wrong");
    a_jog_release_hold: assert property ($fell(jog_mode_out) && valve_enable_out |-> valve_cmd_out == 16'h0000 && required_pos_out == $past(actual_pos_in))
        else $error("jog release did not hold actual");
    a_jog_not_in_position_flag: assert property (jog_mode_out |-> !in_position_flag_out)
        else $error("in position while jogging");
    a_req_tick_hold: assert property ($changed(required_pos_out) |=> $stable(required_pos_out) [*2])
        else $error("required position changed between ticks");
    c_ready: cover property ($rose(ready_out));
    c_in_position_flag: cover property ($rose(in_position_flag_out));
    c_jog: cover property ($fell(jog_mode_out));
endmodule // psc_checker

bind psc_positioning_sequence_control psc_checker #(.CTRL_CYCLES(CTRL_CYCLES)) u_chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .enable_in(enable_in), .start_in(start_in),
    .jog_plus_in(jog_plus_in), .jog_minus_in(jog_minus_in), .demand_pos_in(demand_pos_in),
    .actual_pos_in(actual_pos_in), .ext_speed_in(ext_speed_in),
    .speed_limit_param_in(speed_limit_param_in),
    .speed_source_select_in(speed_source_select_in), .jog_speed_in(jog_speed_in),
    .ready_out(ready_out), .in_position_flag_out(in_position_flag_out),
    .jog_mode_out(jog_mode_out), .valve_enable_out(valve_enable_out),
    .valve_cmd_out(valve_cmd_out), .required_pos_out(required_pos_out));

// ---- verification/psc_plc_model.sv ----
`timescale 1ns/1ps
// Supervising controller: owns the control pins and the demand word
module psc_plc_model (
    input wire clk_sys_in,
    output reg enable_out,
    output reg start_out,
    output reg jog_plus_out,
    output reg jog_minus_out,
    output reg [15:0] demand_pos_out
);
    initial begin
        {enable_out, start_out, jog_plus_out, jog_minus_out} = 4'h0;
        demand_pos_out = 16'h0000;
    end
    // Pins change on the falling edge; fixed output is never used, so jog is safe
    task drive(input logic en, input logic st, input logic jp, input logic jm, input logic [15:0] dem);
        @(negedge clk_sys_in);
        {enable_out, start_out, jog_plus_out, jog_minus_out} = {en, st, jp, jm};
        demand_pos_out = dem;
    endtask
endmodule // psc_plc_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sensor_ok = 1'b1, src_ext = 1'b0, curve_root = 1'b1, nc_mode = 1'b0;
    logic [15:0] actual = 16'h1234, ext_speed = 16'h0040, stroke = 16'h1000, gain = 16'h0100;
    wire enable, start, jog_p, jog_m, ready, in_pos, jog_mode, valve_en;
    wire [15:0] demand, valve_cmd, req_pos;
    int num_errors = 0;
    int n_tests = 0;
    int m;
    always #5 clk_sys_in = ~clk_sys_in;
    psc_plc_model plc (.clk_sys_in(clk_sys_in), .enable_out(enable), .start_out(start),
        .jog_plus_out(jog_p), .jog_minus_out(jog_m), .demand_pos_out(demand));
    psc_positioning_sequence_control #(.CTRL_CYCLES(4)) dut (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .enable_in(enable), .start_in(start), .jog_plus_in(jog_p),
        .jog_minus_in(jog_m), .sensor_ok_in(sensor_ok), .demand_pos_in(demand),
        .actual_pos_in(actual), .ext_speed_in(ext_speed), .decel_stroke_a_in(stroke),
        .decel_stroke_b_in(stroke), .emergency_dist_in(16'h0400), .curve_root_in(curve_root),
        .nc_mode_in(nc_mode), .loop_gain_in(gain), .nc_accel_in(gain),
        .speed_limit_param_in(16'h0800), .speed_source_select_in(src_ext),
        .jog_speed_in(16'h0100), .in_pos_window_in(16'h0010), .ready_out(ready),
        .in_position_flag_out(in_pos), .jog_mode_out(jog_mode), .valve_enable_out(valve_en),
        .valve_cmd_out(valve_cmd), .required_pos_out(req_pos));
    task stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Output selector for the bounded waits
    function logic [15:0] pick(input int w);
        case (w)
            0: pick = {15'h0000, ready};
            1: pick = {15'h0000, in_pos};
            2: pick = {15'h0000, jog_mode};
            3: pick = {15'h0000, valve_en};
            default: pick = req_pos;
        endcase
    endfunction
    task wait_for(input int w, input logic [15:0] exp);
        int i;
        for (i = 0; i < 60 && pick(w) !== exp; i++) @(negedge clk_sys_in);
        check(pick(w), exp);
        if (pick(w) !== exp) stop_test();
    endtask
    initial begin
        repeat (6) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (20) @(negedge clk_sys_in);
        check({12'h000, ready, in_pos, jog_mode, valve_en}, 16'h0000);
        check(valve_cmd, 16'h0000);
        plc.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h2000);
        wait_for(3, 16'h0001);
        check(req_pos, 16'h1234);
        wait_for(0, 16'h0001);
        plc.drive(1'b1, 1'b1, 1'b0, 1'b0, 16'h2000);
        wait_for(4, 16'h2000);
        check({15'h0000, in_pos}, 16'h0000);
        // Each profile mode must push the valve toward the target
        for (m = 0; m < 3; m++) begin
            {curve_root, nc_mode} = (m == 0) ? 2'b10 : (m == 1) ? 2'b00 : 2'b01;
            repeat (16) @(negedge clk_sys_in);
            check({14'h0000, valve_cmd[15], valve_cmd == 16'h0000}, 16'h0000);
            // Root curve gives 16'h03b6, linear 16'h0373 for this error and stroke
            if (m < 2) check(valve_cmd, (m == 0) ? 16'h03b6 : 16'h0373);
        end
        actual = 16'h2000;
        wait_for(1, 16'h0001);
        actual = 16'h2100;
        wait_for(1, 16'h0000);
        actual = 16'h2008;
        wait_for(1, 16'h0001);
        plc.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h2000);
        wait_for(1, 16'h0000);
        wait_for(4, 16'h2008);
        plc.drive(1'b1, 1'b1, 1'b1, 1'b0, 16'h2008);
        repeat (20) @(negedge clk_sys_in);
        check({15'h0000, jog_mode}, 16'h0000);
        plc.drive(1'b1, 1'b0, 1'b1, 1'b0, 16'h2008);
        wait_for(2, 16'h0001);
        check(valve_cmd, 16'h0080);
        actual = 16'h2050;
        plc.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h2008);
        wait_for(2, 16'h0000);
        check(req_pos, 16'h2050);
        check(valve_cmd, 16'h0000);
        sensor_ok = 1'b0;
        plc.drive(1'b1, 1'b0, 1'b0, 1'b1, 16'h2008);
        wait_for(2, 16'h0001);
        check(valve_cmd, 16'hff80);
        plc.drive(1'b1, 1'b0, 1'b1, 1'b1, 16'h2008);
        repeat (20) @(negedge clk_sys_in);
        check({15'h0000, jog_mode}, 16'h0000);
        sensor_ok = 1'b1;
        src_ext = 1'b1;
        plc.drive(1'b1, 1'b0, 1'b1, 1'b0, 16'h2008);
        wait_for(2, 16'h0001);
        check(valve_cmd, 16'h0020);
        plc.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h2008);
        wait_for(2, 16'h0000);
        plc.drive(1'b0, 1'b0, 1'b0, 1'b0, 16'h2008);
        wait_for(3, 16'h0000);
        check({valve_cmd[15:1], ready}, 16'h0000);
        stop_test();
    end
endmodule // testbench

// ---- verilog/psc_defs.vh ----
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSC_CLK_PERIOD_NS 10
`define PSC_CTRL_PERIOD_NS 1000
`define PSC_CTRL_CYCLES (`PSC_CTRL_PERIOD_NS / `PSC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Sequence states
// ----------------------------------------------------------------
`define PSC_ST_OFF 3'h0
`define PSC_ST_HOLD 3'h1
`define PSC_ST_MOVE 3'h2
`define PSC_ST_JOG 3'h3
`define PSC_ST_STOP 3'h4

// ----------------------------------------------------------------
// Synchroniser bit positions and reset values
// ----------------------------------------------------------------
`define PSC_SYNC_ENABLE 0
`define PSC_SYNC_START 1
`define PSC_SYNC_JOGP 2
`define PSC_SYNC_JOGM 3
`define PSC_SYNC_RESET 4'h0
`define PSC_ZERO16 16'h0000
`define PSC_FULL16 16'hffff

`endif

// ---- verilog/psc_positioning_sequence_control.v ----
`timescale 1ns/1ps
`include "psc_defs.vh"

module psc_positioning_sequence_control #(
    parameter CTRL_CYCLES = `PSC_CTRL_CYCLES // Clocks per control update
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire enable_in, // Pin, synchronised here
    input wire start_in, // Pin, synchronised here
    input wire jog_plus_in, // Pin, synchronised here
    input wire jog_minus_in, // Pin, synchronised here
    input wire sensor_ok_in, // Position sensor healthy
    input wire [15:0] demand_pos_in, // Analogue target, converted
    input wire [15:0] actual_pos_in, // Measured position
    input wire [15:0] ext_speed_in, // External speed demand
    input wire [15:0] decel_stroke_a_in, // Deceleration stroke, plus travel
    input wire [15:0] decel_stroke_b_in, // Deceleration stroke, minus travel
    input wire [15:0] emergency_dist_in, // Stopping distance on start loss
    input wire curve_root_in, // 1: root curve (default), 0: linear
    input wire nc_mode_in, // 1: numerical-control profile
    input wire [15:0] loop_gain_in, // NC loop gain, 8.8 fixed point
    input wire [15:0] nc_accel_in, // NC speed step per update
    input wire [15:0] speed_limit_param_in, // Internal velocity limit
    input wire speed_source_select_in, // 1: source_external
    input wire [15:0] jog_speed_in, // Programmed manual speed
    input wire [15:0] in_pos_window_in, // Reached-position tolerance
    output reg ready_out,
    output reg in_position_flag_out,
    output reg jog_mode_out,
    output reg valve_enable_out,
    output reg [15:0] valve_cmd_out, // Signed, full scale = 10 V
    output reg [15:0] required_pos_out
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Smaller of two unsigned words
    function [15:0] min16;
        input [15:0] a;
        input [15:0] b;
        begin
            min16 = (a < b) ? a : b;
        end
    endfunction

    // Error over stroke as 0.16 fraction, saturated at one
    function [15:0] ratio16;
        input [15:0] mag;
        input [15:0] stroke;
        reg [31:0] q;
        begin
            q = 32'h0000_0000;
            if (stroke == `PSC_ZERO16 || mag >= stroke) begin
                ratio16 = `PSC_FULL16;
            end else begin
                q = {mag, 16'h0000} / {16'h0000, stroke};
                ratio16 = q[15:0];
            end
        end
    endfunction

    // Integer square root, bitwise; gives the near-quadratic braking curve
    function [15:0] isqrt32;
        input [31:0] v;
        reg [31:0] rem;
        reg [15:0] root;
        reg [15:0] trial;
        integer i;
        begin
            rem = v;
            root = `PSC_ZERO16;
            trial = `PSC_ZERO16;
            for (i = 15; i >= 0; i = i - 1) begin
                trial = root | (16'h0001 << i);
                if ({16'h0000, trial} * {16'h0000, trial} <= rem) begin
                    root = trial;
                end
            end
            isqrt32 = root;
        end
    endfunction

    // Unsigned 0.16 fraction times word
    function [15:0] scale16;
        input [15:0] frac;
        input [15:0] word;
        reg [31:0] p;
        begin
            p = frac * word;
            scale16 = p[31:16];
        end
    endfunction

    // Magnitude to signed valve word, halved to fit the sign bit
    function [15:0] to_valve;
        input [15:0] mag;
        input up;
        begin
            to_valve = up ? {1'b0, mag[15:1]} : (`PSC_ZERO16 - {1'b0, mag[15:1]});
        end
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers and control-rate divider
    // ----------------------------------------------------------------
    reg [3:0] sync_meta; // First stage, read only by sync_q
    reg [3:0] sync_q; // Second stage, safe to use
    reg [15:0] div_count; // Control update divider
    reg ctrl_tick; // One-cycle update enable

    // Two-flop capture of the supervisor pins
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sync_meta <= `PSC_SYNC_RESET;
            sync_q <= `PSC_SYNC_RESET;
        end else begin
            sync_meta <= {jog_minus_in, jog_plus_in, start_in, enable_in};
            sync_q <= sync_meta;
        end
    end

    // Divider; the loop math is heavy, so it only has to settle per update
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            div_count <= `PSC_ZERO16;
            ctrl_tick <= 1'b0;
        end else if (div_count >= CTRL_CYCLES[15:0] - 16'h0001) begin
            div_count <= `PSC_ZERO16;
            ctrl_tick <= 1'b1;
        end else begin
            div_count <= div_count + 16'h0001;
            ctrl_tick <= 1'b0;
        end
    end

    wire en = sync_q[`PSC_SYNC_ENABLE];
    wire run = sync_q[`PSC_SYNC_START];
    wire jp = sync_q[`PSC_SYNC_JOGP];
    wire jm = sync_q[`PSC_SYNC_JOGM];
    // Start wins over jog; both jogs together cancel out
    wire jog_req = ~run & (jp ^ jm);

    // ----------------------------------------------------------------
    // Loop arithmetic
    // ----------------------------------------------------------------
    reg [2:0] state; // Sequence state
    reg [15:0] nc_speed; // NC profile speed

    wire [16:0] pos_err = {1'b0, required_pos_out} - {1'b0, actual_pos_in};
    wire [16:0] pos_err_neg = 17'h0_0000 - pos_err;
    wire dir_up = ~pos_err[16];
    wire [15:0] err_mag = pos_err[16] ? pos_err_neg[15:0] : pos_err[15:0];
    wire in_window = err_mag <= in_pos_window_in;

    // Speed ceiling from the selected source
    wire [15:0] speed_limit = speed_source_select_in ? ext_speed_in
                                                     : speed_limit_param_in;

    // Braking stroke: emergency distance while stopping, else per direction
    wire [15:0] stroke = (state == `PSC_ST_STOP) ? emergency_dist_in
                       : (dir_up ? decel_stroke_a_in : decel_stroke_b_in);
    wire [15:0] err_ratio = ratio16(err_mag, stroke);
    wire [15:0] curve = curve_root_in ? isqrt32({err_ratio, 16'h0000})
                                      : err_ratio;
    wire [15:0] stroke_speed = scale16(curve, speed_limit);

    // NC target speed: gain times error, clipped to the limit
    wire [31:0] nc_prod = err_mag * loop_gain_in;
    wire [15:0] nc_raw = (nc_prod[31:24] != 8'h00) ? `PSC_FULL16 : nc_prod[23:8];
    wire [15:0] nc_target = min16(nc_raw, speed_limit);
    wire [16:0] nc_up = {1'b0, nc_speed} + {1'b0, nc_accel_in};

    wire [15:0] loop_speed = nc_mode_in ? nc_speed : stroke_speed;
    wire [15:0] jog_speed = min16(jog_speed_in, speed_limit);

    // ----------------------------------------------------------------
    // Sequence and outputs
    // ----------------------------------------------------------------
    // One update per control tick; enable loss acts at once
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state <= `PSC_ST_OFF;
            nc_speed <= `PSC_ZERO16;
            ready_out <= 1'b0;
            in_position_flag_out <= 1'b0;
            jog_mode_out <= 1'b0;
            valve_enable_out <= 1'b0;
            valve_cmd_out <= `PSC_ZERO16;
            required_pos_out <= `PSC_ZERO16;
        end else if (!en) begin
            // Output off and zero until the next enable
            state <= `PSC_ST_OFF;
            nc_speed <= `PSC_ZERO16;
            ready_out <= 1'b0;
            in_position_flag_out <= 1'b0;
            jog_mode_out <= 1'b0;
            valve_enable_out <= 1'b0;
            valve_cmd_out <= `PSC_ZERO16;
        end else if (ctrl_tick) begin
            // NC ramp: rise by acceleration, drop at once so braking never lags
            if (nc_target > nc_speed) begin
                nc_speed <= (nc_up[16] || nc_up[15:0] > nc_target) ? nc_target
                                                                    : nc_up[15:0];
            end else begin
                nc_speed <= nc_target;
            end
            case (state)
                `PSC_ST_OFF: begin
                    // Freeze where the axis stands
                    required_pos_out <= actual_pos_in;
                    valve_enable_out <= 1'b1;
                    valve_cmd_out <= `PSC_ZERO16;
                    state <= `PSC_ST_HOLD;
                end
                `PSC_ST_HOLD, `PSC_ST_MOVE, `PSC_ST_STOP: begin
                    ready_out <= 1'b1;
                    // Closed loop needs the sensor; without it, stand still
                    valve_cmd_out <= sensor_ok_in ? to_valve(loop_speed, dir_up)
                                                  : `PSC_ZERO16;
                    in_position_flag_out <= 1'b0;
                    jog_mode_out <= 1'b0;
                    if (run) begin
                        required_pos_out <= demand_pos_in;
                        state <= `PSC_ST_MOVE;
                        // Flag follows the window while start remains
                        in_position_flag_out <= (state == `PSC_ST_MOVE) & in_window;
                    end else if (state == `PSC_ST_MOVE) begin
                        // Start lost mid-move: brake over the emergency distance
                        required_pos_out <= actual_pos_in;
                        state <= `PSC_ST_STOP;
                    end else if (jog_req) begin
                        state <= `PSC_ST_JOG;
                        jog_mode_out <= 1'b1;
                        // Open loop from the first jog tick, no stale loop command
                        valve_cmd_out <= to_valve(jog_speed, jp);
                    end else if (state == `PSC_ST_STOP && in_window) begin
                        state <= `PSC_ST_HOLD;
                    end
                end
                `PSC_ST_JOG: begin
                    // Open loop, no sensor needed
                    if (jog_req) begin
                        valve_cmd_out <= to_valve(jog_speed, jp);
                        jog_mode_out <= 1'b1;
                    end else begin
                        // Release, start or both jogs: hold the present spot
                        required_pos_out <= actual_pos_in;
                        valve_cmd_out <= `PSC_ZERO16;
                        jog_mode_out <= 1'b0;
                        state <= `PSC_ST_HOLD;
                    end
                end
                default: begin
                    state <= `PSC_ST_OFF;
                end
            endcase
        end
    end

endmodule // psc_positioning_sequence_control
